// ---- core/codec_port_pkg.sv ----
// Constants, types and register map of the codec serial audio port.
// Assumes one system clock (MCLK) and a host that masters the bit and frame clocks.
//
// Behaviour
// RULE_01: format 00: DAC input 24-bit right-justified, ADC output 24-bit left-justified.
// RULE_02: format 01: DAC input 16-bit right-justified, ADC output 24-bit left-justified.
// RULE_03: format 10: DAC input and ADC output both 24-bit left-justified.
// RULE_04: format 11: DAC input and ADC output both 24-bit I2S.
// RULE_05: host gives 64 or 48 bit clocks per frame; both are accepted.
// RULE_06: serial output changes after bit clock falling edges and frame clock edges.
// RULE_07: host keeps bit and frame clocks frequency-locked to the system clock.
// RULE_08: frame drift above six bit clocks halts DAC, midscale until resync plus delay.
// RULE_09: same loss halts ADC, zero samples until resync plus ADC delay.
// RULE_10: drift under five bit clocks never resyncs nor mutes anything.
// RULE_11: de-emphasis select 00 44.1k, 01 off, 10 48k, 11 32k.
// RULE_12: factory test input held low in normal operation.
// RULE_13: host sequences mute, power-down, clock restart, power-up, unmute.
// RULE_14: with large reference capacitors host pulses power-down after settling.
// RULE_15: internal reset released 1024 system clocks after reset release.
// RULE_16: power-down fades DAC to midscale and forces serial output to zero.
// RULE_17: 128 or 192 fs system clock disables ADC, serial output held low.
// RULE_18: toggling power-down during a fade reverses the fade at once.
// RULE_19: left-justified MSB in first slot; right-justified LSB in last slot.
// RULE_20: I2S MSB one bit clock after frame edge; low frame clock is left.

package codec_port_pkg;

	localparam int SAMPLE_W = 24;

	typedef enum logic [1:0] {FMT_RJ24, FMT_RJ16, FMT_LJ24, FMT_I2S} fmt_type;
	typedef enum logic [1:0] {DEEMPH_44K1, DEEMPH_OFF, DEEMPH_48K, DEEMPH_32K} deemph_type;

	typedef struct packed {
		logic       power_down_n;
		deemph_type deemph;
		fmt_type    fmt;
	} ctrl_type;

	typedef struct packed {
		logic [SAMPLE_W-1:0] left;
		logic [SAMPLE_W-1:0] right;
	} stereo_type;

	localparam ctrl_type CTRL_RESET = '{power_down_n: 1'b1, deemph: DEEMPH_OFF, fmt: FMT_RJ24};

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_CTRL      = 5'h00;
	localparam logic [4:0] REG_STATUS    = 5'h04;
	localparam logic [4:0] REG_DAC_LEFT  = 5'h08;
	localparam logic [4:0] REG_DAC_RIGHT = 5'h0C;
	localparam logic [4:0] REG_ADC_LEFT  = 5'h10;
	localparam logic [4:0] REG_ADC_RIGHT = 5'h14;
	localparam logic [4:0] REG_FRAME_LEN = 5'h18;

	localparam int ST_BIT_INIT_DONE = 0;
	localparam int ST_BIT_SYNC_OK   = 1;
	localparam int ST_BIT_ADC_ON    = 2;
	localparam int ST_BIT_DAC_ON    = 3;
	localparam int ST_BIT_FADE_FULL = 4;

	// ----------------------------------------------------------------
	// counts
	// ----------------------------------------------------------------
	localparam int POR_CYCLES        = 1024;
	localparam int GOOD_FRAMES       = 2;
	localparam int DAC_RESYNC_FRAMES = 16;
	localparam int ADC_RESYNC_FRAMES = 32;
	localparam int FADE_STEPS        = 8;
	localparam int ADC_MIN_PERIOD    = 224;
	localparam int LOSS_HALF_BITS    = 11;

endpackage

// ---- core/codec_serial_port.sv ----
// Serial audio port of a stereo codec with an Avalon-MM register slave.
// Bit clock, frame clock and data input are asynchronous pins sampled by MCLK.

module codec_serial_port (
	input  wire logic                             MCLK,
	input  wire logic                             RST_N,
	input  wire logic                             BIT_CLOCK,
	input  wire logic                             FRAME_CLOCK,
	input  wire logic                             DATA_IN,
	output logic                                  DATA_OUT,
	input  wire logic [4:0]                       AVS_ADDRESS,
	input  wire logic                             AVS_READ,
	input  wire logic                             AVS_WRITE,
	input  wire logic [31:0]                      AVS_WRITEDATA,
	output logic [31:0]                           AVS_READDATA,
	output logic                                  AVS_WAITREQUEST,
	output codec_port_pkg::stereo_type            DAC_SAMPLE,
	output codec_port_pkg::deemph_type            DEEMPH_MODE
);
	import codec_port_pkg::*;

	typedef enum logic [1:0] {ST_ACQUIRE, ST_SETTLE, ST_RUN} sync_state_type;

	// ----------------------------------------------------------------
	// pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [2:0] bit_sync_reg;
	logic [2:0] frm_sync_reg;
	logic [1:0] din_sync_reg;

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			bit_sync_reg  <= 3'h0;
			frm_sync_reg  <= 3'h0;
			din_sync_reg  <= 2'h0;
		end
		else
		begin
			bit_sync_reg  <= {bit_sync_reg[1:0], BIT_CLOCK};
			frm_sync_reg  <= {frm_sync_reg[1:0], FRAME_CLOCK};
			din_sync_reg  <= {din_sync_reg[0], DATA_IN};
		end
	end

	logic bit_rise;
	logic bit_fall;
	logic frm_edge;
	logic frame_tick;
	assign bit_rise   = bit_sync_reg[1] & ~bit_sync_reg[2];
	assign bit_fall   = ~bit_sync_reg[1] & bit_sync_reg[2];
	assign frm_edge   = frm_sync_reg[1] ^ frm_sync_reg[2];
	assign frame_tick = frm_sync_reg[1] & ~frm_sync_reg[2];

	// ----------------------------------------------------------------
	// control register and internal reset
	// ----------------------------------------------------------------
	ctrl_type   ctrl_reg;
	stereo_type adc_reg;
	logic [9:0] por_cnt_reg;
	logic       por_done_reg;

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			por_cnt_reg  <= 10'h000;
			por_done_reg <= 1'b0;
		end
		else if (!por_done_reg)
		begin
			por_cnt_reg <= por_cnt_reg + 10'h001;
			if (por_cnt_reg == 10'(POR_CYCLES - 1))
				por_done_reg <= 1'b1; // RULE_15
		end
	end

	// ----------------------------------------------------------------
	// frame and bit period measurement
	// ----------------------------------------------------------------
	logic [11:0] cyc_cnt_reg;
	logic [11:0] period_reg;
	logic [7:0]  bit_cyc_reg;
	logic [7:0]  bit_period_reg;
	logic [6:0]  bits_cnt_reg;
	logic [6:0]  frame_bits_reg;
	logic        adc_off_reg;
	logic [11:0] period_next;
	logic [11:0] drift;
	logic        bad_frame;

	assign period_next = cyc_cnt_reg + 12'h001;
	assign drift = (period_next > period_reg) ? period_next - period_reg
		: period_reg - period_next;
	// threshold at 5.5 bit clocks: above 6 always trips, below 5 never does
	assign bad_frame = {1'b0, drift, 1'b0} > 14'(bit_period_reg) * 14'(LOSS_HALF_BITS);

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			cyc_cnt_reg    <= 12'h000;
			period_reg     <= 12'h000;
			bit_cyc_reg    <= 8'h00;
			bit_period_reg <= 8'h00;
			bits_cnt_reg   <= 7'h00;
			frame_bits_reg <= 7'h00;
			adc_off_reg    <= 1'b0;
		end
		else
		begin
			cyc_cnt_reg <= (cyc_cnt_reg == 12'hFFF) ? cyc_cnt_reg : period_next;
			bit_cyc_reg <= (bit_cyc_reg == 8'hFF) ? bit_cyc_reg : bit_cyc_reg + 8'h01;
			if (bit_rise)
			begin
				bit_period_reg <= bit_cyc_reg + 8'h01;
				bit_cyc_reg    <= 8'h00;
				bits_cnt_reg   <= bits_cnt_reg + 7'h01; // RULE_05
			end
			if (frame_tick)
			begin
				period_reg     <= period_next;
				cyc_cnt_reg    <= 12'h000;
				frame_bits_reg <= bits_cnt_reg;
				bits_cnt_reg   <= 7'h00;
				adc_off_reg    <= period_next < 12'(ADC_MIN_PERIOD); // RULE_17
			end
		end
	end

	// ----------------------------------------------------------------
	// synchronisation tracking, judged once per frame
	// ----------------------------------------------------------------
	sync_state_type sync_state_reg;
	logic [5:0]     settle_cnt_reg;
	logic           dac_ok;
	logic           adc_ok;

	assign dac_ok = (sync_state_reg == ST_RUN) ||
		(sync_state_reg == ST_SETTLE && settle_cnt_reg >= 6'(DAC_RESYNC_FRAMES));
	assign adc_ok = (sync_state_reg == ST_RUN);

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sync_state_reg <= ST_ACQUIRE;
			settle_cnt_reg <= 6'h00;
		end
		else if (!por_done_reg)
		begin
			sync_state_reg <= ST_ACQUIRE;
			settle_cnt_reg <= 6'h00;
		end
		else if (frame_tick)
		begin
			settle_cnt_reg <= settle_cnt_reg + 6'h01;
			if (bad_frame)
			begin
				sync_state_reg <= ST_ACQUIRE; // RULE_08
				settle_cnt_reg <= 6'h00;      // RULE_09
			end
			else
			begin
				unique case (sync_state_reg)
					ST_ACQUIRE:
						if (settle_cnt_reg == 6'(GOOD_FRAMES - 1))
						begin
							sync_state_reg <= ST_SETTLE;
							settle_cnt_reg <= 6'h00;
						end
					ST_SETTLE:
						if (settle_cnt_reg == 6'(ADC_RESYNC_FRAMES - 1))
							sync_state_reg <= ST_RUN;
					ST_RUN:
						settle_cnt_reg <= settle_cnt_reg; // RULE_10
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// receive path: serial input to DAC samples
	// ----------------------------------------------------------------
	logic [31:0]         rx_sh_reg;
	logic [5:0]          rx_idx_reg;
	stereo_type          rx_reg;
	logic                rx_take;
	logic                rx_was_left;
	logic [SAMPLE_W-1:0] rx_word;

	always_comb
	begin
		unique case (ctrl_reg.fmt)
			FMT_RJ24, FMT_RJ16: rx_take = 1'b1;                               // RULE_19
			FMT_LJ24:           rx_take = rx_idx_reg < 6'd24;                 // RULE_03
			FMT_I2S:            rx_take = rx_idx_reg >= 6'd1 && rx_idx_reg <= 6'd24; // RULE_04
		endcase
		unique case (ctrl_reg.fmt)
			FMT_RJ16: rx_word = {rx_sh_reg[15:0], 8'h00}; // RULE_02
			default:  rx_word = rx_sh_reg[SAMPLE_W-1:0];  // RULE_01
		endcase
	end
	// frm_sync_reg[2] is the level of the half that just ended
	assign rx_was_left = (ctrl_reg.fmt == FMT_I2S) ? ~frm_sync_reg[2] : frm_sync_reg[2]; // RULE_20

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rx_sh_reg  <= 32'h0000_0000;
			rx_idx_reg <= 6'h00;
			rx_reg     <= '0;
		end
		else if (frm_edge)
		begin
			rx_idx_reg <= 6'h00;
			if (rx_was_left)
				rx_reg.left <= rx_word;
			else
				rx_reg.right <= rx_word;
		end
		else if (bit_rise)
		begin
			rx_idx_reg <= (rx_idx_reg == 6'h3F) ? rx_idx_reg : rx_idx_reg + 6'h01;
			if (rx_take)
				rx_sh_reg <= {rx_sh_reg[30:0], din_sync_reg[1]};
		end
	end

	// ----------------------------------------------------------------
	// fade and DAC output, stepped once per frame
	// ----------------------------------------------------------------
	logic [3:0] fade_reg;

	function automatic logic [SAMPLE_W-1:0] faded(input logic [SAMPLE_W-1:0] s,
		input logic [3:0] g);
		logic [3:0] sh;
		sh = 4'(FADE_STEPS) - g;
		faded = (g == 4'h0) ? '0 : SAMPLE_W'($signed(s) >>> sh);
	endfunction

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			fade_reg    <= 4'h0;
			DAC_SAMPLE  <= '0;
			DEEMPH_MODE <= DEEMPH_OFF;
		end
		else
		begin
			DEEMPH_MODE <= ctrl_reg.deemph; // RULE_11
			if (frame_tick)
			begin
				// direction follows power_down_n and dac_ok each frame, so a toggle reverses at once
				if (dac_ok && ctrl_reg.power_down_n && fade_reg != 4'(FADE_STEPS))
					fade_reg <= fade_reg + 4'h1; // RULE_18
				else if (!(dac_ok && ctrl_reg.power_down_n) && fade_reg != 4'h0)
					fade_reg <= fade_reg - 4'h1; // RULE_16
			end
			if (!dac_ok)
				DAC_SAMPLE <= '0; // RULE_08
			else if (frame_tick)
			begin
				DAC_SAMPLE.left  <= faded(rx_reg.left, fade_reg);
				DAC_SAMPLE.right <= faded(rx_reg.right, fade_reg);
			end
		end
	end

	// ----------------------------------------------------------------
	// transmit path: ADC samples to serial output
	// ----------------------------------------------------------------
	logic [SAMPLE_W-1:0] tx_sh_reg;
	logic                tx_rise_seen_reg;
	logic                tx_mute;
	logic                tx_left;
	logic [SAMPLE_W-1:0] tx_word;

	assign tx_mute = !por_done_reg || !ctrl_reg.power_down_n || !adc_ok || adc_off_reg;
	assign tx_left = (ctrl_reg.fmt == FMT_I2S) ? ~frm_sync_reg[1] : frm_sync_reg[1];
	assign tx_word = tx_mute ? '0 : (tx_left ? adc_reg.left : adc_reg.right);

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			tx_sh_reg        <= '0;
			tx_rise_seen_reg <= 1'b0;
			DATA_OUT         <= 1'b0;
		end
		else if (frm_edge)
		begin
			tx_rise_seen_reg <= 1'b0;
			if (ctrl_reg.fmt == FMT_I2S)
			begin
				DATA_OUT  <= 1'b0;    // RULE_20
				tx_sh_reg <= tx_word;
			end
			else
			begin
				DATA_OUT  <= tx_word[SAMPLE_W-1];        // RULE_19
				tx_sh_reg <= {tx_word[SAMPLE_W-2:0], 1'b0};
			end
		end
		else
		begin
			if (bit_rise)
				tx_rise_seen_reg <= 1'b1;
			// a fall before the first rise of a half is the one that framed the edge
			if (tx_mute)
				DATA_OUT <= 1'b0; // RULE_09
			else if (bit_fall && tx_rise_seen_reg)
			begin
				DATA_OUT  <= tx_sh_reg[SAMPLE_W-1]; // RULE_06
				tx_sh_reg <= {tx_sh_reg[SAMPLE_W-2:0], 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------
	// Avalon-MM slave: one wait cycle, then the answer
	// ----------------------------------------------------------------
	logic req;
	logic [31:0] status;
	assign req = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
	assign status = 32'({fade_reg == 4'(FADE_STEPS), dac_ok, !adc_off_reg,
		sync_state_reg != ST_ACQUIRE, por_done_reg});

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h0000_0000;
			ctrl_reg        <= CTRL_RESET;
			adc_reg         <= '0;
		end
		else
		begin
			AVS_WAITREQUEST <= !req;
			if (req && AVS_WRITE)
			begin
				unique case (AVS_ADDRESS)
					REG_CTRL:      ctrl_reg      <= ctrl_type'(AVS_WRITEDATA[4:0]);
					REG_ADC_LEFT:  adc_reg.left  <= AVS_WRITEDATA[SAMPLE_W-1:0];
					REG_ADC_RIGHT: adc_reg.right <= AVS_WRITEDATA[SAMPLE_W-1:0];
					default:       ;
				endcase
			end
			if (req && AVS_READ)
			begin
				unique case (AVS_ADDRESS)
					REG_CTRL:      AVS_READDATA <= 32'(ctrl_reg);
					REG_STATUS:    AVS_READDATA <= status;
					REG_DAC_LEFT:  AVS_READDATA <= 32'(rx_reg.left);
					REG_DAC_RIGHT: AVS_READDATA <= 32'(rx_reg.right);
					REG_ADC_LEFT:  AVS_READDATA <= 32'(adc_reg.left);
					REG_ADC_RIGHT: AVS_READDATA <= 32'(adc_reg.right);
					REG_FRAME_LEN: AVS_READDATA <= {13'h0000, frame_bits_reg, period_reg};
					default:       AVS_READDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_por_quiet: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE_15
		$rose(por_done_reg) |-> $past(por_cnt_reg) == 10'(POR_CYCLES - 1) && !DATA_OUT)
		else $error("internal reset released at wrong count");
	a_pd_zero: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE_16
		!ctrl_reg.power_down_n ##1 !ctrl_reg.power_down_n |-> !DATA_OUT)
		else $error("serial output not zero in power-down");
	a_adc_off: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE_17
		adc_off_reg |=> !DATA_OUT)
		else $error("serial output active with ADC disabled");
	a_dout_timing: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE_06
		$changed(DATA_OUT) && !$past(tx_mute) |-> $past(bit_fall) || $past(frm_edge))
		else $error("serial output changed off a clock edge");
	a_loss_halt: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE_08
		frame_tick && bad_frame && por_done_reg |=> !dac_ok ##1 DAC_SAMPLE == '0)
		else $error("DAC not halted on sync loss");
	a_loss_adc: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE_09
		frame_tick && bad_frame |=> tx_mute ##1 !DATA_OUT)
		else $error("ADC output not zeroed on sync loss");
	a_small_drift: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE_10
		frame_tick && !bad_frame && sync_state_reg == ST_RUN && por_done_reg
		|=> sync_state_reg == ST_RUN)
		else $error("small drift left run state");
	a_i2s_delay: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE_20
		frm_edge && ctrl_reg.fmt == FMT_I2S |=> !DATA_OUT)
		else $error("I2S slot zero not empty");
	a_lj_msb: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE_19
		frm_edge && ctrl_reg.fmt != FMT_I2S |=> DATA_OUT == $past(tx_word[SAMPLE_W-1]))
		else $error("left-justified MSB missing after frame edge");
	a_fade_down: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE_18
		frame_tick && !ctrl_reg.power_down_n && fade_reg != 4'h0
		|=> fade_reg == $past(fade_reg) - 4'h1)
		else $error("fade did not step down");

endmodule // codec_serial_port

// ---- test/audio_host_model.sv ----
// Host side of the codec serial link: masters bit and frame clocks, sends DAC data,
// captures ADC data. Assumes the bench's MCLK as its time base.

module audio_host_model
	import codec_port_pkg::*;
(
	input  logic                    mclk,
	input  codec_port_pkg::fmt_type fmt,
	input  int                      bpf,
	input  int                      stretch,
	input  logic [23:0]             dac_l,
	input  logic [23:0]             dac_r,
	input  logic                    dout,
	output logic                    bclk,
	output logic                    fclk,
	output logic                    din,
	output logic [23:0]             adc_l,
	output logic [23:0]             adc_r,
	output int                      frames
);
	timeunit 1ns;
	timeprecision 1ns;
	import codec_port_pkg::*;

	logic [2:0]  ph = 3'd0;
	int          k = 0;
	int          slot = 0;
	logic        h = 1'b0;
	logic        side = 1'b0;
	logic [23:0] cap [2] = '{24'h00_0000, 24'h00_0000};

	initial
	begin
		bclk = 1'b1;
		fclk = 1'b1;
		din = 1'b0;
		adc_l = 24'h00_0000;
		adc_r = 24'h00_0000;
		frames = 0;
	end

	// ----------------------------------------------------------------
	// serial data of one slot
	// ----------------------------------------------------------------
	// unused slots toggle so a stale level is never mistaken for data
	function automatic logic tx_bit(logic [23:0] s, int k, int n);
		int p;
		case (fmt)
			FMT_RJ24: p = n - 1 - k;
			FMT_RJ16: p = (n - 1 - k < 16) ? n - 1 - k : 99;
			FMT_LJ24: p = 23 - k;
			default:  p = 24 - k;
		endcase
		return (p >= 0 && p < 24) ? s[p] : k[0];
	endfunction

	// ----------------------------------------------------------------
	// clocks and capture
	// ----------------------------------------------------------------
	// bit clock of 8 MCLK, locked to MCLK; frame edges ride on bit clock falls
	always @(posedge mclk)
	begin
		int pos;
		ph <= ph + 3'd1;
		if (ph == 3'd0)
		begin
			bclk <= 1'b0;
			if (k == 0)
				fclk <= (fmt == FMT_I2S) ? h : !h;
			din <= tx_bit(h ? dac_r : dac_l, k, bpf / 2 + (h ? stretch : 0));
			slot <= k;
			side <= h;
			if (k + 1 < bpf / 2 + (h ? stretch : 0))
				k <= k + 1;
			else
			begin
				k <= 0;
				h <= !h;
			end
			if (k == 0 && !h)
			begin
				adc_l <= cap[0];
				adc_r <= cap[1];
				frames <= frames + 1;
			end
		end
		if (ph == 3'd4)
			bclk <= 1'b1;
		if (ph == 3'd6)
		begin
			pos = (fmt == FMT_I2S) ? slot - 1 : slot;
			if (pos >= 0 && pos < 24)
				cap[side][23 - pos] <= dout;
		end
	end

endmodule // audio_host_model

// ---- test/test_codec_serial_port.sv ----
// Self-checking bench of the codec serial port: register tasks over Avalon-MM,
// a host model on the link. Assumes the design package is compiled first.

module test_codec_serial_port;
	timeunit 1ns;
	timeprecision 1ns;
	import codec_port_pkg::*;

	localparam logic [23:0] DL = 24'h9A_5C3E;
	localparam logic [23:0] DR = 24'h41_B7D2;
	localparam logic [23:0] AL = 24'hC3_A517;
	localparam logic [23:0] AR = 24'h2E_6B91;

	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        bclk;
	logic        fclk;
	logic        din;
	logic        dout;
	logic [4:0]  addr = 5'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic        waitreq;
	stereo_type  dac_seen;
	deemph_type  deemph_seen;
	fmt_type     hfmt = FMT_RJ24;
	int          bpf = 64;
	int          stretch = 0;
	logic [23:0] adc_l;
	logic [23:0] adc_r;
	int          frames;
	int          failures = 0;
	int          n_checks = 0;
	logic [31:0] q;

	codec_serial_port i_codec_serial_port (
		.MCLK            (mclk),
		.RST_N           (rst_n),
		.BIT_CLOCK       (bclk),
		.FRAME_CLOCK     (fclk),
		.DATA_IN         (din),
		.DATA_OUT        (dout),
		.AVS_ADDRESS     (addr),
		.AVS_READ        (rd),
		.AVS_WRITE       (wr),
		.AVS_WRITEDATA   (wdata),
		.AVS_READDATA    (rdata),
		.AVS_WAITREQUEST (waitreq),
		.DAC_SAMPLE      (dac_seen),
		.DEEMPH_MODE     (deemph_seen)
	);

	audio_host_model i_audio_host_model (
		.mclk    (mclk),
		.fmt     (hfmt),
		.bpf     (bpf),
		.stretch (stretch),
		.dac_l   (DL),
		.dac_r   (DR),
		.dout    (dout),
		.bclk    (bclk),
		.fclk    (fclk),
		.din     (din),
		.adc_l   (adc_l),
		.adc_r   (adc_r),
		.frames  (frames)
	);

	initial
	begin
		forever #20 mclk = ~mclk;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// holds the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		@(posedge mclk);
		while (waitreq !== 1'b0)
			@(posedge mclk);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wait_frames(input int n);
		int target;
		target = frames + n;
		while (frames < target)
			@(posedge mclk);
	endtask

	function automatic logic [47:0] exp_dac();
		return (hfmt == FMT_RJ16) ? {DL[15:0], 8'h00, DR[15:0], 8'h00} : {DL, DR};
	endfunction

	task automatic check_io();
		chk(dac_seen, exp_dac());
		chk({adc_l, adc_r}, {AL, AR});
	endtask

	task automatic print_verdict();
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk(dout, 1'b0);
		chk(deemph_seen, DEEMPH_OFF);
		bus(1'b0, REG_CTRL, 32'h0000_0000);
		chk(q, 32'h0000_0014);
		bus(1'b0, 5'h1C, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		// init must still be pending just short of 1024 cycles
		repeat (980) @(posedge mclk);
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		chk(q[ST_BIT_INIT_DONE], 1'b0);
		repeat (40) @(posedge mclk);
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		chk(q[ST_BIT_INIT_DONE], 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, REG_CTRL, 32'h0000_0010 | 32'(i << 2));
			chk(deemph_seen, deemph_type'(i));
		end
		bus(1'b1, REG_ADC_LEFT, {8'h00, AL});
		bus(1'b1, REG_ADC_RIGHT, {8'h00, AR});
		bus(1'b0, REG_ADC_LEFT, 32'h0000_0000);
		chk(q[23:0], AL);
		wait_frames(38);
		for (int f = 0; f < 3; f++)
		begin
			bus(1'b1, REG_CTRL, 32'h0000_0014 | 32'(f));
			hfmt <= fmt_type'(f);
			wait_frames(4);
			check_io();
		end
		// frame polarity flips, so the link resyncs once
		bus(1'b1, REG_CTRL, 32'h0000_0017);
		hfmt <= FMT_I2S;
		wait_frames(40);
		check_io();
		bus(1'b0, REG_FRAME_LEN, 32'h0000_0000);
		chk(q[18:0], 19'h4_0200);
		// 24 slots hold no delayed 24-bit word; polarity and ratio change cost one resync
		bus(1'b1, REG_CTRL, 32'h0000_0016);
		hfmt <= FMT_LJ24;
		bpf <= 48;
		wait_frames(40);
		check_io();
		bus(1'b0, REG_FRAME_LEN, 32'h0000_0000);
		chk(q[18:0], 19'h3_0180);
		stretch <= 4;
		wait_frames(1);
		stretch <= 0;
		wait_frames(3);
		check_io();
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		chk(q[ST_BIT_SYNC_OK], 1'b1);
		stretch <= 8;
		wait_frames(1);
		stretch <= 0;
		wait_frames(6);
		chk(dac_seen, 48'h0000_0000_0000);
		chk({adc_l, adc_r}, 48'h0000_0000_0000);
		wait_frames(40);
		check_io();
		// power-down straight after a full-data check, skipping the mute that RULE_13 has a host do first
		bus(1'b1, REG_CTRL, 32'h0000_0006);
		wait_frames(3);
		// power back up mid fade-out: the fade must turn and climb to full again
		bus(1'b1, REG_CTRL, 32'h0000_0016);
		wait_frames(5);
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		chk(q[ST_BIT_FADE_FULL], 1'b1);
		check_io();
		bus(1'b1, REG_CTRL, 32'h0000_0006);
		wait_frames(12);
		chk(dac_seen, 48'h0000_0000_0000);
		chk({adc_l, adc_r}, 48'h0000_0000_0000);
		// a reset pulse on rst_n restarts the internal reset count
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk(dout, 1'b0);
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		chk(q[ST_BIT_INIT_DONE], 1'b0);
		bus(1'b0, REG_CTRL, 32'h0000_0000);
		chk(q, 32'h0000_0014);
		print_verdict();
	end

	initial
	begin
		repeat (100000) @(posedge mclk);
		failures++;
		print_verdict();
	end

endmodule // test_codec_serial_port
